// file: src/mmp_pkg.sv
// package: register map, reset values, field layout and state types of the io port mux
package mmp_pkg;

  localparam logic [7:0] ADDR_PORT0_DATA       = 8'h80;
  localparam logic [7:0] ADDR_PORT1_DATA       = 8'h90;
  localparam logic [7:0] ADDR_PORT0_OE         = 8'h91;
  localparam logic [7:0] ADDR_PORT2_OE         = 8'h93;
  localparam logic [7:0] ADDR_PORT2_DATA       = 8'hA0;
  localparam logic [7:0] ADDR_PORT1_MODE_LOW   = 8'hA2;
  localparam logic [7:0] ADDR_PORT1_MODE_HIGH  = 8'hA3;
  localparam logic [7:0] ADDR_PORT3_MODE_LOW   = 8'hA4;
  localparam logic [7:0] ADDR_PORT3_MODE_HIGH  = 8'hA5;
  localparam logic [7:0] ADDR_RC_OSC_CTRL      = 8'hAF;
  localparam logic [7:0] ADDR_PORT3_DATA       = 8'hB0;
  localparam logic [7:0] ADDR_SERIAL_CTRL      = 8'hBC;
  localparam logic [7:0] ADDR_PIN_FUNC_SEL     = 8'hBF;
  localparam logic [7:0] ADDR_CLOCK_SRC_CTRL   = 8'hD8;

  localparam logic [7:0] RST_PORT_DATA         = 8'hFF;
  localparam logic [7:0] RST_ZERO              = 8'h00;
  localparam logic [7:0] RST_RC_OSC_CTRL       = 8'h0C;
  localparam logic [7:0] RST_CLOCK_SRC_CTRL    = 8'h00;

  // writable bits; the others read as zero
  localparam logic [7:0] MASK_PORT2_OE         = 8'h7F;
  localparam logic [7:0] MASK_SERIAL_CTRL      = 8'hF7;
  localparam logic [7:0] MASK_PIN_FUNC_SEL     = 8'hE0;

  localparam int         SERIAL_ENABLE_BIT     = 7;
  localparam int         RC_PIN_COUNT_LSB      = 6;
  localparam int         BUS_ENABLE_BIT        = 7;
  localparam int         STROBE_POLARITY_BIT   = 6;
  localparam int         PULSE_OUT_ENABLE_BIT  = 5;
  localparam int         FAST_XTAL_SEL_BIT     = 6;
  localparam int         SLOW_XTAL_TYPE_BIT    = 4;

  localparam logic [1:0] MODE_QUASI            = 2'h0;
  localparam logic [1:0] MODE_OPEN_DRAIN       = 2'h1;
  localparam logic [1:0] MODE_PUSH_PULL        = 2'h2;
  localparam logic [1:0] MODE_ALTERNATE        = 2'h3;

  // strong high drive after a low-to-high step, in clock cycles
  localparam logic [1:0] KICK_CYCLES           = 2'h2;
  localparam int         PSEUDO_PINS           = 11;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] ie;
  } mmp_pad_t;

  typedef struct packed {
    logic [7:0]                   p0;
    logic [7:0]                   p1;
    logic [7:0]                   p2;
    logic [7:0]                   p3;
    logic [7:0]                   p0oe;
    logic [7:0]                   port2_drive_enable_bits;
    logic [15:0]                  p1mode;
    logic [15:0]                  p3mode;
    logic [7:0]                   rc_oscillator_pin_control;
    logic [7:0]                   serial_periph_control;
    logic [7:0]                   pin_function_select;
    logic [7:0]                   clock_source_control;
    logic [7:0]                   rdata;
    logic [PSEUDO_PINS-1:0][1:0]  kick;
    logic [7:0]                   in0;
    logic [7:0]                   in1;
    logic [7:0]                   in2;
    logic [7:0]                   in3;
  } mmp_state_t;

endpackage : mmp_pkg

// file: src/mmp_io_port_mux.sv
// module: multi-mode io port mux for four 8-bit ports with register slave
`timescale 1ns/1ps
`default_nettype none
module mmp_io_port_mux
  import mmp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_rmw,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic [7:0] p0_pin_in,
  input  wire logic [7:0] p1_pin_in,
  input  wire logic [7:0] p2_pin_in,
  input  wire logic [7:0] p3_pin_in,
  output mmp_pad_t        p0_pad,
  output mmp_pad_t        p1_pad,
  output mmp_pad_t        p2_pad,
  output mmp_pad_t        p3_pad,
  input  wire logic       timer2_divided_clock_out,
  input  wire logic       timer1_divided_clock_out,
  input  wire logic       timer1_inverted_clock_out,
  input  wire logic       system_clock_divided_out,
  input  wire logic       pulse_width_in,
  input  wire logic [2:0] spi_dout,
  input  wire logic [2:0] spi_doe,
  input  wire logic [7:0] bus_dout,
  input  wire logic       bus_doe,
  input  wire logic       bus_rd,
  input  wire logic       bus_wr,
  output logic      [7:0] port0_in,
  output logic      [7:0] port1_in,
  output logic      [7:0] port2_in,
  output logic      [7:0] port3_in,
  output logic      [7:0] port1_analog_sel,
  output logic            touch_charge_collect,
  output logic      [3:0] rc_converter_pins,
  output logic            fast_crystal_en,
  output logic            slow_crystal_en,
  output logic            serial_periph_enable,
  output logic            parallel_bus_enable
);

  logic       rst_sync1_q;
  logic       rst_sync2_q;
  mmp_state_t st_q;
  mmp_state_t st_d;
  logic       pwm_en;
  logic       strobe_pol;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  function automatic logic [1:0] mode_of(input logic [15:0] m, input int n);
    mode_of = m[2*n +: 2];
  endfunction : mode_of

  assign pwm_en               = st_q.pin_function_select[PULSE_OUT_ENABLE_BIT];
  assign strobe_pol           = st_q.pin_function_select[STROBE_POLARITY_BIT];
  assign serial_periph_enable = st_q.serial_periph_control[SERIAL_ENABLE_BIT];
  assign parallel_bus_enable  = st_q.pin_function_select[BUS_ENABLE_BIT];
  assign fast_crystal_en      = st_q.clock_source_control[FAST_XTAL_SEL_BIT];
  assign slow_crystal_en      = st_q.clock_source_control[SLOW_XTAL_TYPE_BIT];
  assign sfr_rdata            = st_q.rdata;
  assign port0_in             = st_q.in0;
  assign port1_in             = st_q.in1;
  assign port2_in             = st_q.in2;
  assign port3_in             = st_q.in3;

  always_comb begin
    unique case (st_q.rc_oscillator_pin_control[RC_PIN_COUNT_LSB +: 2])
      2'h0:    rc_converter_pins = 4'h0;
      2'h1:    rc_converter_pins = 4'h3;
      2'h2:    rc_converter_pins = 4'h7;
      default: rc_converter_pins = 4'hF;
    endcase
  end

  always_comb begin
    for (int n = 0; n < 8; n++) begin
      port1_analog_sel[n] = (mode_of(st_q.p1mode, n) == MODE_ALTERNATE) && (n != 0);
    end
    touch_charge_collect = (mode_of(st_q.p3mode, 4) == MODE_ALTERNATE);
  end

  // register writes, reads, kick counters and registered digital inputs
  always_comb begin
    logic [1:0] m;
    logic       old_d;
    logic       new_d;
    m     = 2'h0;
    old_d = 1'b0;
    new_d = 1'b0;
    st_d  = st_q;
    if (sfr_wr) begin
      if (sfr_addr == ADDR_PORT0_DATA) begin
        st_d.p0 = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT1_DATA) begin
        st_d.p1 = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT0_OE) begin
        st_d.p0oe = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT2_OE) begin
        st_d.port2_drive_enable_bits = sfr_wdata & MASK_PORT2_OE;
      end else if (sfr_addr == ADDR_PORT2_DATA) begin
        st_d.p2 = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT1_MODE_LOW) begin
        st_d.p1mode[7:0] = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT1_MODE_HIGH) begin
        st_d.p1mode[15:8] = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT3_MODE_LOW) begin
        st_d.p3mode[7:0] = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT3_MODE_HIGH) begin
        st_d.p3mode[15:8] = sfr_wdata;
      end else if (sfr_addr == ADDR_RC_OSC_CTRL) begin
        st_d.rc_oscillator_pin_control = sfr_wdata;
      end else if (sfr_addr == ADDR_PORT3_DATA) begin
        st_d.p3 = sfr_wdata;
      end else if (sfr_addr == ADDR_SERIAL_CTRL) begin
        st_d.serial_periph_control = sfr_wdata & MASK_SERIAL_CTRL;
      end else if (sfr_addr == ADDR_PIN_FUNC_SEL) begin
        st_d.pin_function_select = sfr_wdata & MASK_PIN_FUNC_SEL;
      end else if (sfr_addr == ADDR_CLOCK_SRC_CTRL) begin
        st_d.clock_source_control = sfr_wdata;
      end
    end
    if (sfr_rd) begin
      // plain reads of a port see the pins, rmw reads see the latch
      if (sfr_addr == ADDR_PORT0_DATA) begin
        st_d.rdata = sfr_rmw ? st_q.p0 : p0_pin_in;
      end else if (sfr_addr == ADDR_PORT1_DATA) begin
        st_d.rdata = sfr_rmw ? st_q.p1 : p1_pin_in;
      end else if (sfr_addr == ADDR_PORT2_DATA) begin
        st_d.rdata = sfr_rmw ? st_q.p2 : p2_pin_in;
      end else if (sfr_addr == ADDR_PORT3_DATA) begin
        st_d.rdata = sfr_rmw ? st_q.p3 : p3_pin_in;
      end else if (sfr_addr == ADDR_PORT0_OE) begin
        st_d.rdata = st_q.p0oe;
      end else if (sfr_addr == ADDR_PORT2_OE) begin
        st_d.rdata = st_q.port2_drive_enable_bits;
      end else if (sfr_addr == ADDR_PORT1_MODE_LOW) begin
        st_d.rdata = st_q.p1mode[7:0];
      end else if (sfr_addr == ADDR_PORT1_MODE_HIGH) begin
        st_d.rdata = st_q.p1mode[15:8];
      end else if (sfr_addr == ADDR_PORT3_MODE_LOW) begin
        st_d.rdata = st_q.p3mode[7:0];
      end else if (sfr_addr == ADDR_PORT3_MODE_HIGH) begin
        st_d.rdata = st_q.p3mode[15:8];
      end else if (sfr_addr == ADDR_RC_OSC_CTRL) begin
        st_d.rdata = st_q.rc_oscillator_pin_control;
      end else if (sfr_addr == ADDR_SERIAL_CTRL) begin
        st_d.rdata = st_q.serial_periph_control;
      end else if (sfr_addr == ADDR_PIN_FUNC_SEL) begin
        st_d.rdata = st_q.pin_function_select;
      end else if (sfr_addr == ADDR_CLOCK_SRC_CTRL) begin
        st_d.rdata = st_q.clock_source_control;
      end else begin
        st_d.rdata = RST_ZERO;
      end
    end
    // pseudo open drain pins: 0..7 port1, 8..10 port3 pins 0-2
    for (int k = 0; k < PSEUDO_PINS; k++) begin
      if (k < 8) begin
        m     = mode_of(st_q.p1mode, k);
        old_d = st_q.p1[k];
        new_d = st_d.p1[k];
      end else begin
        m     = mode_of(st_q.p3mode, k - 8);
        old_d = st_q.p3[k-8];
        new_d = st_d.p3[k-8];
      end
      if (!old_d && new_d && (m == MODE_QUASI || m == MODE_OPEN_DRAIN)) begin
        st_d.kick[k] = KICK_CYCLES;
      end else if (st_q.kick[k] != 2'h0) begin
        st_d.kick[k] = st_q.kick[k] - 2'h1;
      end
    end
    st_d.in0 = p0_pin_in & p0_pad.ie;
    st_d.in1 = p1_pin_in & p1_pad.ie;
    st_d.in2 = p2_pin_in & p2_pad.ie;
    st_d.in3 = p3_pin_in & p3_pad.ie;
  end

  always_ff @(posedge ref_clk or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      st_q.p0      <= RST_PORT_DATA;
      st_q.p1      <= RST_PORT_DATA;
      st_q.p2      <= RST_PORT_DATA;
      st_q.p3      <= RST_PORT_DATA;
      st_q.p0oe    <= RST_ZERO;
      st_q.port2_drive_enable_bits    <= RST_ZERO;
      st_q.p1mode  <= {RST_ZERO, RST_ZERO};
      st_q.p3mode  <= {RST_ZERO, RST_ZERO};
      st_q.rc_oscillator_pin_control   <= RST_RC_OSC_CTRL;
      st_q.serial_periph_control   <= RST_ZERO;
      st_q.pin_function_select <= RST_ZERO;
      st_q.clock_source_control  <= RST_CLOCK_SRC_CTRL;
      st_q.rdata   <= RST_ZERO;
      st_q.kick    <= '0;
      st_q.in0     <= RST_ZERO;
      st_q.in1     <= RST_ZERO;
      st_q.in2     <= RST_ZERO;
      st_q.in3     <= RST_ZERO;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // pad drive for ports 1 and 3
  always_comb begin
    logic [1:0] m;
    logic       d;
    logic       alt;
    m   = 2'h0;
    d   = 1'b0;
    alt = 1'b0;
    p1_pad = '0;
    p3_pad = '0;
    for (int n = 0; n < 8; n++) begin
      m = mode_of(st_q.p1mode, n);
      d = st_q.p1[n];
      if (n == 3 && pwm_en) begin
        d = pulse_width_in;
        if (m == MODE_PUSH_PULL) begin
          p1_pad.oe[n]   = 1'b1;
          p1_pad.dout[n] = d;
        end else if (m != MODE_ALTERNATE) begin
          p1_pad.oe[n] = ~d | (st_q.kick[n] != 2'h0);
          p1_pad.dout[n] = d;
          p1_pad.pu[n] = d && (m == MODE_QUASI);
        end
      end else if (m == MODE_ALTERNATE) begin
        if (n == 0) begin
          p1_pad.oe[n]   = 1'b1;
          p1_pad.dout[n] = timer2_divided_clock_out;
        end
      end else if (m == MODE_PUSH_PULL) begin
        p1_pad.oe[n]   = 1'b1;
        p1_pad.dout[n] = d;
      end else begin
        p1_pad.oe[n]   = ~d | (st_q.kick[n] != 2'h0);
        p1_pad.dout[n] = d;
        p1_pad.pu[n]   = d && (m == MODE_QUASI);
        p1_pad.ie[n]   = d;
      end
    end
    for (int n = 0; n < 8; n++) begin
      m   = mode_of(st_q.p3mode, n);
      d   = st_q.p3[n];
      alt = 1'b0;
      if (n >= 6 && parallel_bus_enable) begin
        p3_pad.oe[n]   = 1'b1;
        p3_pad.dout[n] = ((n == 6) ? bus_wr : bus_rd) ~^ strobe_pol;
      end else if (m == MODE_ALTERNATE) begin
        if (n == 5) begin
          alt = timer1_divided_clock_out;
        end else if (n == 6) begin
          alt = timer1_inverted_clock_out;
        end else if (n == 7) begin
          alt = system_clock_divided_out;
        end
        p3_pad.oe[n]   = (n >= 5);
        p3_pad.dout[n] = alt;
      end else if (m == MODE_PUSH_PULL) begin
        p3_pad.oe[n]   = 1'b1;
        p3_pad.dout[n] = d;
      end else begin
        p3_pad.oe[n]   = ~d | ((n < 3) && (st_q.kick[n+8] != 2'h0));
        p3_pad.dout[n] = d;
        p3_pad.pu[n]   = d && (m == MODE_QUASI);
        p3_pad.ie[n]   = d;
      end
    end
  end

  // pad drive for ports 0 and 2
  always_comb begin
    p0_pad = '0;
    p2_pad = '0;
    for (int n = 0; n < 8; n++) begin
      if (n < 4 && rc_converter_pins[n]) begin
        p0_pad.oe[n] = 1'b0;
      end else if (parallel_bus_enable) begin
        p0_pad.oe[n]   = bus_doe;
        p0_pad.dout[n] = bus_dout[n];
        p0_pad.pu[n]   = st_q.p0[n] & ~bus_doe;
        p0_pad.ie[n]   = ~bus_doe;
      end else begin
        p0_pad.oe[n]   = st_q.p0oe[n];
        p0_pad.dout[n] = st_q.p0[n];
        p0_pad.pu[n]   = st_q.p0[n] & ~st_q.p0oe[n];
        p0_pad.ie[n]   = ~st_q.p0oe[n];
      end
    end
    for (int n = 0; n < 7; n++) begin
      if (n >= 4 && serial_periph_enable) begin
        p2_pad.oe[n]   = spi_doe[n-4];
        p2_pad.dout[n] = spi_dout[n-4];
        p2_pad.ie[n]   = ~spi_doe[n-4];
      end else if ((n < 2 && slow_crystal_en) || (n >= 2 && n < 4 && fast_crystal_en)) begin
        p2_pad.oe[n] = 1'b0;
      end else begin
        p2_pad.oe[n]   = st_q.port2_drive_enable_bits[n];
        p2_pad.dout[n] = st_q.p2[n];
        p2_pad.pu[n]   = st_q.p2[n] & ~st_q.port2_drive_enable_bits[n];
        p2_pad.ie[n]   = ~st_q.port2_drive_enable_bits[n];
      end
    end
    p2_pad.pu[7]   = 1'b1;
    p2_pad.oe[7]   = ~st_q.p2[7];
    p2_pad.dout[7] = 1'b0;
    p2_pad.ie[7]   = 1'b1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync2_q);

  a_rmw_latch: assert property (ce && sfr_rd && sfr_rmw && sfr_addr == ADDR_PORT1_DATA
    |=> sfr_rdata == $past(st_q.p1)) else $error("rmw read did not return latch");
  a_quasi_low: assert property (st_q.p3mode[3:2] == MODE_QUASI && !st_q.p3[1]
    |-> p3_pad.oe[1] && !p3_pad.dout[1] && !p3_pad.pu[1]) else $error("mode0 low wrong");
  a_push_pull: assert property (st_q.p1mode[5:4] == MODE_PUSH_PULL
    |-> p1_pad.oe[2] && p1_pad.dout[2] == st_q.p1[2] && !p1_pad.ie[2])
    else $error("mode2 drive wrong");
  a_alt_release: assert property (st_q.p1mode[3:2] == MODE_ALTERNATE
    |-> !p1_pad.oe[1] && !p1_pad.pu[1] && !p1_pad.ie[1] && port1_analog_sel[1])
    else $error("mode3 pin not released");
  a_kick_strong: assert property ($rose(st_q.p1[2]) && $past(st_q.p1mode[5:4]) == MODE_QUASI
    && ce |-> p1_pad.oe[2] && p1_pad.dout[2] ##1 ce |-> p1_pad.oe[2])
    else $error("strong high kick missing");
  a_kick_ends: assert property (st_q.p1mode[5:4] == MODE_QUASI && st_q.p1[2]
    && st_q.kick[2] == 2'h0 |-> !p1_pad.oe[2] && p1_pad.pu[2]) else $error("kick too long");
  a_open_drain: assert property (st_q.p3mode[7:6] == MODE_OPEN_DRAIN && st_q.p3[3]
    |-> !p3_pad.oe[3] && !p3_pad.pu[3] && p3_pad.ie[3]) else $error("true open drain wrong");
  a_p27_pullup: assert property (p2_pad.pu[7] && (p2_pad.oe[7] == !st_q.p2[7]))
    else $error("port2 pin7 wrong");
  a_p0_drive: assert property (!parallel_bus_enable && rc_converter_pins == 4'h0
    |-> p0_pad.oe == st_q.p0oe && p0_pad.pu == (st_q.p0 & ~st_q.p0oe))
    else $error("port0 drive wrong");
  a_strobe_pol: assert property (parallel_bus_enable && st_q.p3mode[15:14] != 2'h0 ||
    parallel_bus_enable |-> p3_pad.dout[7] == (strobe_pol ? bus_rd : !bus_rd))
    else $error("strobe polarity wrong");
  a_pwm_off: assert property (!pwm_en && st_q.p1mode[7:6] == MODE_QUASI && st_q.p1[3]
    && st_q.kick[3] == 2'h0 |-> !p1_pad.oe[3]) else $error("pulse leaked to pin");
  a_reset_data: assert property ($rose(rst_sync2_q) |-> st_q.p1 == RST_PORT_DATA
    && st_q.p1mode == 16'h0000) else $error("reset values wrong");

  c_kick:    cover property ($rose(st_q.p1[0]) && p1_pad.oe[0]);
  c_bus:     cover property (parallel_bus_enable && bus_doe);
  c_spi:     cover property (serial_periph_enable && spi_doe[0]);
  c_clk_out: cover property (st_q.p3mode[15:14] == MODE_ALTERNATE);

endmodule : mmp_io_port_mux
`default_nettype wire

// file: test/mmp_board_model.sv
// board around the pins: strong external drive, pull-ups, floating lines
`timescale 1ns/1ps
`default_nettype none
module mmp_board_model
  import mmp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire mmp_pad_t    p0_pad,
  input  wire mmp_pad_t    p1_pad,
  input  wire mmp_pad_t    p2_pad,
  input  wire mmp_pad_t    p3_pad,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output logic      [7:0]  p0_pin_in,
  output logic      [7:0]  p1_pin_in,
  output logic      [7:0]  p2_pin_in,
  output logic      [7:0]  p3_pin_in
);
  // undriven, unpulled lines toggle so a stale value never passes
  logic [7:0] float_q = 8'h55;

  always_ff @(posedge ref_clk) float_q <= ~float_q;

  function automatic logic [7:0] lvl(mmp_pad_t p, logic [7:0] ee, logic [7:0] ev,
                                     logic [7:0] fl);
    return (p.oe & p.dout) | (~p.oe & ee & ev) | (~p.oe & ~ee & p.pu)
         | (~p.oe & ~ee & ~p.pu & fl);
  endfunction : lvl

  assign p0_pin_in = lvl(p0_pad, ext_en[7:0], ext_val[7:0], float_q);
  assign p1_pin_in = lvl(p1_pad, ext_en[15:8], ext_val[15:8], float_q);
  assign p2_pin_in = lvl(p2_pad, ext_en[23:16], ext_val[23:16], float_q);
  assign p3_pin_in = lvl(p3_pad, ext_en[31:24], ext_val[31:24], float_q);
endmodule : mmp_board_model
`default_nettype wire

// file: test/tb_multi_mode_io_port_mux.sv
// self-checking bench for the io port mux
`timescale 1ns/1ps
`default_nettype none
module tb_multi_mode_io_port_mux
  import mmp_pkg::*;
;
  logic        ref_clk, reset_n, ce, sfr_wr, sfr_rd, sfr_rmw, t2c, t1c, t1i, sysc, pw;
  logic        bus_doe, bus_rd, bus_wr, touch, fxe, sxe, spe, pbe;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, bus_dout, pin0, pin1, pin2, pin3;
  logic [7:0]  in0, in1, in2, in3, asel;
  logic [3:0]  rcp;
  logic [2:0]  spi_dout, spi_doe;
  logic [31:0] ext_en, ext_val;
  mmp_pad_t    p0_pad, p1_pad, p2_pad, p3_pad;
  int          n_fail, num_checks;

  mmp_io_port_mux dut (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .p0_pin_in(pin0), .p1_pin_in(pin1), .p2_pin_in(pin2),
    .p3_pin_in(pin3), .p0_pad(p0_pad), .p1_pad(p1_pad), .p2_pad(p2_pad), .p3_pad(p3_pad),
    .timer2_divided_clock_out(t2c), .timer1_divided_clock_out(t1c),
    .timer1_inverted_clock_out(t1i), .system_clock_divided_out(sysc),
    .pulse_width_in(pw), .spi_dout(spi_dout), .spi_doe(spi_doe), .bus_dout(bus_dout),
    .bus_doe(bus_doe), .bus_rd(bus_rd), .bus_wr(bus_wr), .port0_in(in0), .port1_in(in1),
    .port2_in(in2), .port3_in(in3), .port1_analog_sel(asel), .touch_charge_collect(touch),
    .rc_converter_pins(rcp), .fast_crystal_en(fxe), .slow_crystal_en(sxe),
    .serial_periph_enable(spe), .parallel_bus_enable(pbe));

  mmp_board_model board (.ref_clk(ref_clk), .p0_pad(p0_pad), .p1_pad(p1_pad),
    .p2_pad(p2_pad), .p3_pad(p3_pad), .ext_en(ext_en), .ext_val(ext_val),
    .p0_pin_in(pin0), .p1_pin_in(pin1), .p2_pin_in(pin2), .p3_pin_in(pin3));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic r, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rmw  <= r;
    sfr_rd   <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1;
    chk(sfr_rdata, exp);
  endtask : rdc

  task automatic t_reset;
    logic [15:0] tab [14] = '{16'h80FF, 16'h90FF, 16'h9100, 16'h9300, 16'hA0FF, 16'hA200,
      16'hA300, 16'hA400, 16'hA500, 16'hAF0C, 16'hB0FF, 16'hBC00, 16'hBF00, 16'hD800};
    for (int i = 0; i < 14; i++) rdc(tab[i][15:8], 1'b1, tab[i][7:0]);
    chk({p1_pad.oe, p1_pad.pu, p1_pad.ie}, 24'h00FFFF);
    rdc(8'h81, 1'b0, 8'h00);
  endtask : t_reset

  task automatic t_modes;
    logic [3:0] ex [4] = '{4'b0110, 4'b0010, 4'b1001, 4'b1001};
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_PORT1_MODE_LOW, {6'h00, m[1:0]});
      chk({p1_pad.oe[0], p1_pad.pu[0], p1_pad.ie[0], p1_pad.oe[0] & p1_pad.dout[0]}, ex[m]);
    end
    @(posedge ref_clk) t2c <= 1'b0;
    @(posedge ref_clk) #1;
    chk(p1_pad.dout[0], 1'b0);
    wr(ADDR_PORT1_MODE_LOW, 8'h00);
    wr(ADDR_PORT1_MODE_HIGH, 8'hC0);
    chk({asel, p1_pad.ie[7], p1_pad.pu[7]}, 10'h200);
    wr(ADDR_PORT1_MODE_HIGH, 8'h00);
  endtask : t_modes

  task automatic t_kick;
    wr(ADDR_PORT1_DATA, 8'hFE);
    chk({p1_pad.oe[0], p1_pad.dout[0], p1_pad.pu[0]}, 3'b100);
    wr(ADDR_PORT1_DATA, 8'hFF);
    chk({p1_pad.oe[0], p1_pad.dout[0]}, 2'b11);
    @(posedge ref_clk) #1;
    chk({p1_pad.oe[0], p1_pad.dout[0]}, 2'b11);
    @(posedge ref_clk) #1;
    chk({p1_pad.oe[0], p1_pad.pu[0]}, 2'b01);
    wr(ADDR_PORT3_DATA, 8'hF6);
    wr(ADDR_PORT3_DATA, 8'hFF);
    chk({p3_pad.oe[0], p3_pad.oe[3], p3_pad.pu[3]}, 3'b101);
    wr(ADDR_PORT1_MODE_LOW, 8'h01);
    wr(ADDR_PORT1_DATA, 8'hFE);
    wr(ADDR_PORT1_DATA, 8'hFF);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({p1_pad.oe[0], p1_pad.pu[0], p1_pad.ie[0]}, 3'b001);
    wr(ADDR_PORT1_MODE_LOW, 8'h00);
  endtask : t_kick

  task automatic t_rmw;
    @(posedge ref_clk);
    ext_en[15:8]  <= 8'hFF;
    ext_val[15:8] <= 8'hF0;
    rdc(ADDR_PORT1_DATA, 1'b0, 8'hF0);
    rdc(ADDR_PORT1_DATA, 1'b1, 8'hFF);
    chk(in1, 8'hF0);
    @(posedge ref_clk) ce <= 1'b0;
    wr(ADDR_PORT1_DATA, 8'h00);
    @(posedge ref_clk) ce <= 1'b1;
    rdc(ADDR_PORT1_DATA, 1'b1, 8'hFF);
    @(posedge ref_clk) ext_en <= '0;
  endtask : t_rmw

  task automatic t_port02;
    wr(ADDR_PORT0_OE, 8'h0F);
    wr(ADDR_PORT0_DATA, 8'h35);
    chk({p0_pad.oe, p0_pad.dout & p0_pad.oe, p0_pad.pu, p0_pad.ie}, 32'h0F0530F0);
    wr(ADDR_PORT2_OE, 8'hFF);
    rdc(ADDR_PORT2_OE, 1'b0, 8'h7F);
    wr(ADDR_PORT2_DATA, 8'h7F);
    chk({p2_pad.oe[7], p2_pad.dout[7], p2_pad.pu[7]}, 3'b101);
    wr(ADDR_PORT2_DATA, 8'hFF);
    chk({p2_pad.oe[7], p2_pad.pu[7], p2_pad.oe[6:0], p2_pad.dout[6:0]}, 16'h7FFF);
    wr(ADDR_PORT0_OE, 8'h00);
    wr(ADDR_PORT2_OE, 8'h00);
  endtask : t_port02

  task automatic t_periph;
    logic [3:0] rct [4] = '{4'h0, 4'h3, 4'h7, 4'hF};
    logic [5:0] pwt [5] = '{6'h24, 6'h2E, 6'h04, 6'h09, 6'h18};
    @(posedge ref_clk);
    spi_dout <= 3'b101;
    spi_doe  <= 3'b011;
    wr(ADDR_SERIAL_CTRL, 8'hFF);
    rdc(ADDR_SERIAL_CTRL, 1'b0, 8'hF7);
    chk({spe, p2_pad.oe[6:4], p2_pad.dout[5:4]}, 6'h2D);
    wr(ADDR_SERIAL_CTRL, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_RC_OSC_CTRL, {k[1:0], 6'h0C});
      chk(rcp, rct[k]);
    end
    wr(ADDR_RC_OSC_CTRL, 8'h0C);
    @(posedge ref_clk);
    bus_dout <= 8'hA5;
    bus_doe  <= 1'b1;
    bus_rd   <= 1'b1;
    wr(ADDR_PIN_FUNC_SEL, 8'h80);
    chk({pbe, p0_pad.oe, p0_pad.dout, p3_pad.oe[7:6], p3_pad.dout[7:6]}, 21'h1FFA5D);
    wr(ADDR_PIN_FUNC_SEL, 8'hC0);
    chk(p3_pad.dout[7:6], 2'b10);
    @(posedge ref_clk) bus_doe <= 1'b0;
    @(posedge ref_clk) #1;
    chk(p0_pad.pu, 8'h35);
    wr(ADDR_PIN_FUNC_SEL, 8'h20);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk) pw <= pwt[i][3];
      wr(ADDR_PORT1_MODE_LOW, {pwt[i][5:4], 6'h00});
      chk({p1_pad.oe[3], p1_pad.dout[3] & p1_pad.oe[3], p1_pad.pu[3]}, pwt[i][2:0]);
    end
    @(posedge ref_clk) pw <= 1'b0;
    wr(ADDR_PORT1_MODE_LOW, 8'h80);
    wr(ADDR_PIN_FUNC_SEL, 8'h00);
    chk({p1_pad.oe[3], p1_pad.dout[3]}, 2'b11);
    wr(ADDR_PORT1_MODE_LOW, 8'h00);
    wr(ADDR_CLOCK_SRC_CTRL, 8'h50);
    chk({fxe, sxe, p2_pad.oe[3:0], p2_pad.pu[3:0]}, 10'h300);
    wr(ADDR_CLOCK_SRC_CTRL, 8'h00);
    @(posedge ref_clk);
    t1c  <= 1'b1;
    sysc <= 1'b1;
    wr(ADDR_PORT3_MODE_HIGH, 8'hFF);
    chk({p3_pad.oe[7:4], p3_pad.dout[7:5], touch}, 8'hEB);
    wr(ADDR_PORT3_MODE_HIGH, 8'h00);
  endtask : t_periph

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    finish_test();
  end

  initial begin
    {reset_n, sfr_wr, sfr_rd, sfr_rmw, t1c, t1i, sysc, pw, bus_doe, bus_rd, bus_wr} = '0;
    {sfr_addr, sfr_wdata, bus_dout, spi_dout, spi_doe, ext_en, ext_val} = '0;
    ce  = 1'b1;
    t2c = 1'b1;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_modes();
    t_kick();
    t_rmw();
    t_port02();
    t_periph();
    finish_test();
  end
endmodule : tb_multi_mode_io_port_mux
`default_nettype wire
